// ### hdl/spi_rb_cfg.svh
`ifndef SPI_RB_CFG_SVH
`define SPI_RB_CFG_SVH
// frame geometry
`define RB_FIRST_BITS 6'h20
`define RB_NEXT_BITS 6'h18
`define RB_CNT_MAX 6'h3f
`define RB_MARK 1'b1
`define RB_CRC_POLY 8'h07
`define RB_CRC_W 8
// host frame field positions
`define RB_FA_HI 30
`define RB_FA_LO 24
`define RB_FD_HI 23
`define RB_FD_LO 8
// device register addresses
`define RB_NOP_ADDR 7'h00
`define RB_RDSEL_ADDR 7'h41
// readback select fields
`define RB_RS_AHI 6
`define RB_RS_ALO 0
`define RB_RS_AUTO 8
`define RB_RS_INFO 9
`define RB_RS_RESET 16'h0000
// software port offsets
`define RB_OFS_STATUS 2'h0
`define RB_OFS_MASK 2'h1
`define RB_OFS_STATE 2'h2
// status bits and pin reset value
`define RB_ST_CNT 0
`define RB_ST_CRC 1
`define RB_ST_RESET 2'h0
`define RB_PIN_RESET 3'h6
`endif

// ### hdl/spi_rb_pkg.sv
package spi_rb_pkg;
  // serial pins as seen by the block
  typedef struct packed {
    logic sclk;
    logic sync_n;
    logic sdi;
  } spi_pins_s;
  // link framing state
  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_FRAME = 2'h2
  } link_state_e;
endpackage : spi_rb_pkg

// ### hdl/spi_stream_auto_readback.sv
// Functional notes
// - stream words while clocks arrive, select low
// - each streamed word steps address by one
// - flag bad rising-edge count at frame end
// - streamed word: data, crc, address option; this block sends data and crc only, no address
// - no register writes while streaming
// - auto readback enable returns chosen register
// - auto readback drives readback address contents
// - new frame restarts at programmed address
// - auto readback streams if select stays low
// - read select frame, data next frame
// - mark bit one from select fall
// - host frame: reserved, address, data, crc
// - crc8 poly 07 guards each write
//
// The implementer's own choices: the plain strobed port and the address map.
`include "spi_rb_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module spi_stream_auto_readback
  import spi_rb_pkg::*;
#(
  parameter int unsigned ADDR_W = 7,
  parameter int unsigned DATA_W = 16
) (
  input wire logic sys_clk_in, // system clock
  input wire logic rst_in, // sync reset, high
  input wire logic clk_en_in, // freezes all state when low
  input wire logic sclk_in, // serial clock pin
  input wire logic sync_n_in, // frame select pin, low
  input wire logic sdi_in, // serial data in pin
  output logic sdo_out, // serial data out pin
  input wire logic [1:0] bus_addr_in, // software address
  input wire logic [15:0] bus_wdata_in, // software write data
  input wire logic bus_wr_in, // software write strobe
  input wire logic bus_rd_in, // software read strobe
  output logic [15:0] bus_rdata_out, // software read data
  output logic irq_out // level interrupt
);

  // pin synchroniser stages
  spi_pins_s pin_q1_r; // first stage, read by second only
  spi_pins_s pin_q2_r; // safe stage
  spi_pins_s pin_q3_r; // edge reference

  // framing state
  link_state_e st_r; // idle or in frame
  logic [5:0] bit_cnt_r; // rising edges in current word
  logic [5:0] fall_cnt_r; // falling edges, saturating
  logic [7:0] words_r; // words completed in frame
  logic [ADDR_W-1:0] ptr_r; // current readback address
  logic [31:0] tx_r; // outgoing shift register
  logic [31:0] rx_r; // incoming shift register

  // device registers
  logic [DATA_W-1:0] mem_r [2**ADDR_W]; // register map
  logic [15:0] read_sel_r; // readback select register
  logic pend_r; // read select written last frame

  // software side
  logic [1:0] status_r; // sticky events
  logic [1:0] mask_r; // interrupt mask

  // combinational helpers
  logic sclk_rise; // synced sclk rising edge
  logic sclk_fall; // synced sclk falling edge
  logic sync_fall; // frame start
  logic sync_rise; // frame end
  logic start_ev; // frame begins
  logic fin_ev; // frame ends
  logic [5:0] word_len; // length of current word
  logic word_done; // last edge of current word
  logic auto_en; // auto readback enabled
  logic ret_info; // return_info_select
  logic [ADDR_W-1:0] start_ptr; // address at frame start
  logic [ADDR_W-1:0] ptr_nxt; // next stream address
  logic [DATA_W-1:0] d_start; // data at start address
  logic [DATA_W-1:0] d_next; // data at next address
  logic [6:0] info; // bits below the mark
  logic crc_ok; // host frame crc matches
  logic len_ok; // edge counts legal
  logic wr_en; // commit host write
  logic crc_err_ev; // crc failure event
  logic cnt_err_ev; // clock_count_error_flag event
  logic [1:0] set_ev; // status set vector
  logic [1:0] clr_ev; // status clear vector

  // crc8 over 24 bits, msb first
  function automatic logic [7:0] crc8(input logic [23:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? `RB_CRC_POLY : 8'h00);
    end
    return c;
  endfunction : crc8

  // two-flop synchronisers plus edge reference
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      pin_q1_r <= `RB_PIN_RESET;
      pin_q2_r <= `RB_PIN_RESET;
      pin_q3_r <= `RB_PIN_RESET;
    end else if (clk_en_in) begin
      pin_q1_r <= '{sclk: sclk_in, sync_n: sync_n_in, sdi: sdi_in};
      pin_q2_r <= pin_q1_r;
      pin_q3_r <= pin_q2_r;
    end
  end

  // edge detection on synced pins
  always_comb begin
    sclk_rise = pin_q2_r.sclk & ~pin_q3_r.sclk;
    sclk_fall = ~pin_q2_r.sclk & pin_q3_r.sclk;
    sync_fall = ~pin_q2_r.sync_n & pin_q3_r.sync_n;
    sync_rise = pin_q2_r.sync_n & ~pin_q3_r.sync_n;
    start_ev = (st_r == ST_IDLE) & sync_fall;
    fin_ev = (st_r == ST_FRAME) & sync_rise;
  end

  // readback selection and word content
  always_comb begin
    auto_en = read_sel_r[`RB_RS_AUTO];
    ret_info = read_sel_r[`RB_RS_INFO];
    // auto or pending read picks programmed address
    start_ptr = (auto_en | pend_r) ? read_sel_r[`RB_RS_AHI:`RB_RS_ALO]
                                   : `RB_NOP_ADDR;
    ptr_nxt = ptr_r + 7'h01;
    d_start = (start_ptr == `RB_RDSEL_ADDR) ? read_sel_r : mem_r[start_ptr];
    d_next = (ptr_nxt == `RB_RDSEL_ADDR) ? read_sel_r : mem_r[ptr_nxt];
    // address or status below the mark
    info = ret_info ? {1'b0, irq_out, 5'h00} : start_ptr;
    word_len = (words_r == 8'h00) ? `RB_FIRST_BITS : `RB_NEXT_BITS;
    word_done = sclk_rise & (bit_cnt_r == word_len - 6'h01);
  end

  // frame end checks
  always_comb begin
    crc_ok = crc8(rx_r[31:8]) == rx_r[7:0];
    // one 32-bit word, or 32 plus whole 24-bit words
    len_ok = (bit_cnt_r == 6'h00) & (words_r != 8'h00)
           & ((words_r != 8'h01) | (fall_cnt_r == `RB_FIRST_BITS));
    wr_en = fin_ev & len_ok & (words_r == 8'h01) & crc_ok;
    crc_err_ev = fin_ev & len_ok & (words_r == 8'h01) & ~crc_ok;
    cnt_err_ev = fin_ev & ~len_ok;
    set_ev = 2'h0;
    set_ev[`RB_ST_CNT] = cnt_err_ev;
    set_ev[`RB_ST_CRC] = crc_err_ev;
    clr_ev = (bus_wr_in && bus_addr_in == `RB_OFS_STATUS) ? bus_wdata_in[1:0] : 2'h0;
  end

  // framing state machine
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      st_r <= ST_IDLE;
    end else if (clk_en_in) begin
      case (st_r)
        ST_IDLE: begin
          if (sync_fall) begin
            st_r <= ST_FRAME;
          end
        end
        ST_FRAME: begin
          if (sync_rise) begin
            st_r <= ST_IDLE;
          end
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // edge counters per frame
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      bit_cnt_r <= 6'h00;
      fall_cnt_r <= 6'h00;
      words_r <= 8'h00;
    end else if (clk_en_in) begin
      if (start_ev) begin
        bit_cnt_r <= 6'h00;
        fall_cnt_r <= 6'h00;
        words_r <= 8'h00;
      end else if (st_r == ST_FRAME) begin
        if (word_done) begin
          // word boundary, every later word is 24 bits long
          bit_cnt_r <= 6'h00;
          if (words_r != 8'hff) begin
            words_r <= words_r + 8'h01;
          end
        end else if (sclk_rise) begin
          bit_cnt_r <= bit_cnt_r + 6'h01;
        end
        if (sclk_fall && fall_cnt_r != `RB_CNT_MAX) begin
          fall_cnt_r <= fall_cnt_r + 6'h01;
        end
      end
    end
  end

  // receive shift on falling sclk
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rx_r <= 32'h0000_0000;
    end else if (clk_en_in) begin
      if ((st_r == ST_FRAME) && sclk_fall) begin
        rx_r <= {rx_r[30:0], pin_q2_r.sdi};
      end
    end
  end

  // transmit shift and stream address
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      tx_r <= 32'h0000_0000;
      ptr_r <= `RB_NOP_ADDR;
    end else if (clk_en_in) begin
      if (start_ev) begin
        // mark bit shows from select fall
        tx_r <= {`RB_MARK, info, d_start, crc8({`RB_MARK, info, d_start})};
        ptr_r <= start_ptr;
      end else if (st_r == ST_FRAME) begin
        if (word_done) begin
          // step to next address, its data and crc on top, no address bits
          tx_r <= {d_next, crc8({`RB_MARK, ptr_nxt, d_next}), 8'h00};
          ptr_r <= ptr_nxt;
        end else if (sclk_rise) begin
          tx_r <= {tx_r[30:0], 1'b0};
        end
      end
    end
  end

  // serial output from flop, low outside frames
  assign sdo_out = tx_r[31] & (st_r == ST_FRAME);

  // register map writes from host frames
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < 2**ADDR_W; i++) begin
        mem_r[i] <= '0;
      end
      read_sel_r <= `RB_RS_RESET;
      pend_r <= 1'b0;
    end else if (clk_en_in) begin
      if (fin_ev) begin
        pend_r <= 1'b0;
      end
      if (wr_en) begin
        if (rx_r[`RB_FA_HI:`RB_FA_LO] == `RB_RDSEL_ADDR) begin
          read_sel_r <= rx_r[`RB_FD_HI:`RB_FD_LO];
          pend_r <= 1'b1;
        end else if (rx_r[`RB_FA_HI:`RB_FA_LO] != `RB_NOP_ADDR) begin
          mem_r[rx_r[`RB_FA_HI:`RB_FA_LO]] <= rx_r[`RB_FD_HI:`RB_FD_LO];
        end
      end
    end
  end

  // sticky status, set wins over clear
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      status_r <= `RB_ST_RESET;
    end else if (clk_en_in) begin
      status_r <= (status_r & ~clr_ev) | set_ev;
    end
  end

  // mask register
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      mask_r <= 2'h0;
    end else if (clk_en_in) begin
      if (bus_wr_in && bus_addr_in == `RB_OFS_MASK) begin
        mask_r <= bus_wdata_in[1:0];
      end
    end
  end

  // software read data, one cycle later
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      bus_rdata_out <= 16'h0000;
    end else if (clk_en_in) begin
      if (bus_rd_in) begin
        case (bus_addr_in)
          `RB_OFS_STATUS: bus_rdata_out <= {14'h0000, status_r};
          `RB_OFS_MASK: bus_rdata_out <= {14'h0000, mask_r};
          `RB_OFS_STATE: bus_rdata_out <= {st_r == ST_FRAME, words_r > 8'h01, 7'h00, ptr_r};
          default: bus_rdata_out <= 16'h0000;
        endcase
      end else begin
        bus_rdata_out <= 16'h0000;
      end
    end
  end

  // level interrupt
  assign irq_out = |(status_r & mask_r);

  // checks
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);

  sdo_mark_a: assert property (clk_en_in && start_ev |=> sdo_out)
    else $error("mark bit missing at frame start");
  stream_step_a: assert property (clk_en_in && word_done && st_r == ST_FRAME
    |=> ptr_r == $past(ptr_r) + 7'h01)
    else $error("stream address did not step");
  stream_data_a: assert property (clk_en_in && word_done && st_r == ST_FRAME
    |=> tx_r[31:16] == $past(d_next) && tx_r[7:0] == 8'h00)
    else $error("streamed word not loaded");
  reload_a: assert property (clk_en_in && start_ev && auto_en
    |=> ptr_r == $past(read_sel_r[6:0]) && tx_r[23:8] == $past(d_start))
    else $error("frame did not restart at programmed address");
  no_stream_wr_a: assert property (clk_en_in && fin_ev && words_r > 8'h01
    |=> $stable(mem_r[rx_r[`RB_FA_HI:`RB_FA_LO]]) && $stable(read_sel_r))
    else $error("write during stream");
  cnt_err_a: assert property (clk_en_in && fin_ev && bit_cnt_r != 6'h00
    |=> status_r[`RB_ST_CNT])
    else $error("count error not flagged");
  crc_err_a: assert property (crc_err_ev && clk_en_in
    |=> status_r[`RB_ST_CRC] && $stable(read_sel_r))
    else $error("crc failure not handled");
  irq_level_a: assert property (clk_en_in && |(set_ev & mask_r) |=> irq_out)
    else $error("interrupt not raised");
  info_a: assert property (clk_en_in && start_ev && !ret_info
    |=> tx_r[30:24] == ptr_r)
    else $error("address missing in readback");

  stream_c: cover property (word_done && words_r == 8'h01);
  write_c: cover property (wr_en);
  crc_c: cover property (crc_err_ev);
  cnt_c: cover property (cnt_err_ev);

endmodule : spi_stream_auto_readback
`default_nettype wire

// ### testbench/spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  output logic sclk_out, // serial clock, idles high
  output logic sync_n_out, // frame select, low
  output logic sdi_out, // data to device
  input wire logic sdo_in // data from device
);
  logic [79:0] rx_r; // captured sdo bits, newest lowest
  // idle pins at time zero
  initial begin
    sclk_out = 1'b1;
    sync_n_out = 1'b1;
    sdi_out = 1'b0;
    rx_r = '0;
  end
  // one frame of nbits clock pairs, select low throughout
  task automatic xfer(input logic [31:0] tx, input int nbits);
    rx_r = '0;
    #7;
    sdi_out = tx[31]; // msb first
    sync_n_out = 1'b0; // select held low over all words
    #320;
    for (int i = 0; i < nbits; i++) begin
      sclk_out = 1'b0;
      // late in the low phase: synced sdo may trail the rise by three clocks
      #150;
      rx_r = {rx_r[78:0], sdo_in};
      #10;
      sclk_out = 1'b1;
      sdi_out = (i < 31) ? tx[30 - i] : ~sdi_out; // past the word: toggling filler
      #160;
    end
    #160;
    sync_n_out = 1'b1;
    sdi_out = ~sdi_out; // released line shows no stale value
    #480;
  endtask : xfer
endmodule : spi_host_model
`default_nettype wire

// ### testbench/spi_stream_auto_readback_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "spi_rb_cfg.svh"
module spi_stream_auto_readback_test;
  logic sys_clk_in = 1'b0; // 25 MHz clock
  logic rst_in = 1'b1; // sync reset
  logic sclk, sync_n, sdi, sdo; // serial link
  logic [1:0] addr = 2'h0; // software offset
  logic [15:0] wdata = 16'h0000; // software write data
  logic wr = 1'b0, rd = 1'b0; // strobes
  logic [15:0] rdata; // read data
  logic irq; // interrupt level
  logic en = 1'b1; // clock enable
  logic [79:0] e; // expected sdo bits
  int errors = 0, checks = 0, cycles = 0; // tallies
  always #20 sys_clk_in = ~sys_clk_in; // 40 ns period
  spi_host_model host (.sclk_out(sclk), .sync_n_out(sync_n), .sdi_out(sdi), .sdo_in(sdo));
  spi_stream_auto_readback DUT (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .clk_en_in(en), .sclk_in(sclk),
    .sync_n_in(sync_n), .sdi_in(sdi), .sdo_out(sdo), .bus_addr_in(addr),
    .bus_wdata_in(wdata), .bus_wr_in(wr), .bus_rd_in(rd), .bus_rdata_out(rdata),
    .irq_out(irq));
  // compare and tally
  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // software write, one strobe cycle
  task automatic bwr(input logic [1:0] a, input logic [15:0] d);
    @(posedge sys_clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk_in);
    wr <= 1'b0;
  endtask : bwr
  // software read, data checked in the following cycle
  task automatic brd(input logic [1:0] a, input logic [15:0] exp);
    @(posedge sys_clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk_in);
    rd <= 1'b0;
    @(negedge sys_clk_in);
    chk(80'(rdata), 80'(exp));
  endtask : brd
  // crc8 poly 07, init 0, msb first
  function automatic logic [7:0] crc8(input logic [23:0] x);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ x[i]) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction : crc8
  // host frame
  function automatic logic [31:0] hf(input logic [6:0] a, input logic [15:0] d);
    return {1'b0, a, d, crc8({1'b0, a, d})};
  endfunction : hf
  // first readback word
  function automatic logic [31:0] rw(input logic [6:0] a, input logic [15:0] d);
    return {1'b1, a, d, crc8({1'b1, a, d})};
  endfunction : rw
  // streamed word
  function automatic logic [23:0] sw(input logic [6:0] a, input logic [15:0] d);
    return {d, crc8({1'b1, a, d})};
  endfunction : sw
  // frame with n streamed words, sdo compared
  task automatic rb(input logic [31:0] tx, input int n, input logic [79:0] exp);
    host.xfer(tx, 32 + 24 * n);
    chk(host.rx_r, exp);
  endtask : rb
  // verdict and end of run
  task automatic final_report();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report
  // hang guard
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      final_report();
    end
  end
  // main sequence
  initial begin
    repeat (2) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    brd(`RB_OFS_STATUS, 16'h0000); // status clear after reset
    brd(`RB_OFS_MASK, 16'h0000); // mask clear after reset
    bwr(2'h3, 16'hffff); // unmapped write dropped
    brd(2'h3, 16'h0000); // unmapped reads zero
    host.xfer(hf(7'h05, 16'h1234), 32);
    host.xfer(hf(7'h06, 16'habcd), 32);
    host.xfer(hf(`RB_RDSEL_ADDR, 16'h0005), 32);
    // two extra words, embedded write must be dropped
    e = {rw(7'h05, 16'h1234), sw(7'h06, 16'habcd), sw(7'h07, 16'h0000)};
    rb(hf(7'h05, 16'h5555), 2, e);
    brd(`RB_OFS_STATUS, 16'h0000);
    // stream flag set, pointer one past the last returned word
    brd(`RB_OFS_STATE, 16'h4008);
    // wrong edge count
    host.xfer(hf(7'h05, 16'h7777), 40);
    brd(`RB_OFS_STATUS, 16'h0001);
    chk(80'(irq), 80'h0); // masked flag stays quiet
    bwr(`RB_OFS_MASK, 16'h0003);
    @(negedge sys_clk_in);
    chk(80'(irq), 80'h1); // unmasked flag raises interrupt
    bwr(`RB_OFS_STATUS, 16'h0001);
    @(negedge sys_clk_in);
    chk(80'(irq), 80'h0); // cleared by writing one
    // corrupted check value
    host.xfer(hf(7'h05, 16'h7777) ^ 32'h1, 32);
    brd(`RB_OFS_STATUS, 16'h0002);
    chk(80'(irq), 80'h1); // crc error reaches interrupt
    // frozen block ignores a mask write
    @(posedge sys_clk_in);
    en <= 1'b0;
    bwr(`RB_OFS_MASK, 16'h0000);
    en <= 1'b1;
    @(negedge sys_clk_in);
    chk(80'(irq), 80'h1); // mask kept while enable was low
    bwr(`RB_OFS_STATUS, 16'h0002);
    host.xfer(hf(`RB_RDSEL_ADDR, 16'h0005), 32);
    rb(hf(7'h00, 16'h0000), 0, 80'(rw(7'h05, 16'h1234)));
    // auto readback of register 5
    host.xfer(hf(`RB_RDSEL_ADDR, 16'h0105), 32);
    rb(hf(7'h00, 16'h0000), 0, 80'(rw(7'h05, 16'h1234)));
    rb(hf(7'h06, 16'h4321), 0, 80'(rw(7'h05, 16'h1234)));
    e = 80'({rw(7'h05, 16'h1234), sw(7'h06, 16'h4321)});
    rb(hf(7'h00, 16'h0000), 1, e);
    rb(hf(7'h00, 16'h0000), 0, 80'(rw(7'h05, 16'h1234)));
    // status info in place of address
    host.xfer(hf(`RB_RDSEL_ADDR, 16'h0305), 32);
    rb(hf(7'h00, 16'h0000), 0, 80'(rw(7'h00, 16'h1234)));
    // raise the interrupt, status then shows it below the mark
    host.xfer(hf(7'h00, 16'h0000), 40);
    rb(hf(7'h00, 16'h0000), 0, 80'(rw(7'h20, 16'h1234)));
    final_report();
  end
endmodule : spi_stream_auto_readback_test
`default_nettype wire
